/* inc/cell_bus_pkg.sv */
// cell_bus_pkg: constants and types shared by both ends of the cell bus.
// assumes each end runs on its own 100 MHz system clock with a synchronous reset.
// Operation
// - cells are 53 bytes: 5 header, 48 payload
// - atm end drives transmit data byte
// - phy end drives receive data byte
// - transmit signals timed by own transmit clock
// - receive signals timed by own receive clock
// - low enable marks each valid byte cycle
// - start mark high on first cell byte
// - full low when four or fewer bytes room; phy end holds it high in cell mode
// - transmit cell available when whole cell fits
// - empty low while receive store empty; phy end holds it high in cell mode
// - receive cell available when whole cell held
// - atm stops writes within four after full
// - atm starts writing only when full high
package cell_bus_pkg;
	// cell layout
	localparam int HDR_BYTES = 5;
	localparam int PAY_BYTES = 48;
	localparam int CELL_BYTES = HDR_BYTES + PAY_BYTES;
	localparam logic [5:0] CELL_LAST = 6'(CELL_BYTES - 1);
	// room left when the transmit full indication drops
	localparam int FULL_ROOM = 4;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	// storage at the phy end, in bytes
	localparam int FIFO_DEPTH = 128;
	// reset values
	localparam logic ENB_IDLE_N = 1'b1;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [7:0] DATA_RST = 8'h00;
	typedef logic [7:0] octet_t;
	typedef enum logic {LS_IDLE, LS_CELL} link_state_e;
endpackage : cell_bus_pkg

/* inc/cell_bus_if.sv */
// cell_bus_if: the parallel cell bus between the atm end and the phy end.
// assumes the bench instantiates it once per pair of ends and hands one modport to each end.
`timescale 1ns/1ps
`default_nettype none
interface cell_bus_if;
	// transmit direction, atm to phy
	logic tx_clk;
	cell_bus_pkg::octet_t tx_data;
	logic tx_enb_n;
	logic tx_soc;
	logic tx_full_n;
	logic tx_clav;
	// receive direction, phy to atm
	logic rx_clk;
	cell_bus_pkg::octet_t rx_data;
	logic rx_enb_n;
	logic rx_soc;
	logic rx_empty_n;
	logic rx_clav;

	modport atm (
		output tx_clk, tx_data, tx_enb_n, tx_soc, rx_clk, rx_enb_n,
		input tx_full_n, tx_clav, rx_data, rx_soc, rx_empty_n, rx_clav
	);
	modport phy (
		input tx_clk, tx_data, tx_enb_n, tx_soc, rx_clk, rx_enb_n,
		output tx_full_n, tx_clav, rx_data, rx_soc, rx_empty_n, rx_clav
	);
endinterface : cell_bus_if
`default_nettype wire

/* logic/cell_fifo.sv */
// cell_fifo: byte store with registered level, room and availability.
// assumes push and pop come from logic on the same clock; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module cell_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = cell_bus_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] pop_data,
	output logic [$clog2(DEPTH):0] level_ff,
	output logic room_ff,
	output logic avail_ff
);
	localparam int AW = $clog2(DEPTH);

	// refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_bad_depth
		$error("cell_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] nxt_level;
	wire do_push = push && room_ff;
	wire do_pop = pop && avail_ff;

	// level follows every accepted push and pop
	assign nxt_level = level_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
	assign pop_data = mem[rd_ff];

	// pointers and flags
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_ff <= '0;
			rd_ff <= '0;
			level_ff <= '0;
			room_ff <= 1'b1;
			avail_ff <= 1'b0;
		end else begin
			wr_ff <= wr_ff + AW'(do_push);
			rd_ff <= rd_ff + AW'(do_pop);
			level_ff <= nxt_level;
			room_ff <= nxt_level != (AW+1)'(DEPTH);
			avail_ff <= nxt_level != '0;
		end
	end

	// storage array, no reset needed
	always_ff @(posedge clock) begin
		if (do_push) begin
			mem[wr_ff] <= push_data;
		end
	end
endmodule : cell_fifo
`default_nettype wire

/* logic/phy_port.sv */
// phy_port: phy-layer end of the cell bus, with transmit and receive byte stores.
// assumes the link clocks and atm-driven pins come from another domain and are
// sampled here; the user sides are on this module's own clock.
`timescale 1ns/1ps
`default_nettype none
module phy_port #(
	parameter bit CELL_LEVEL = 1'b0,
	parameter int DEPTH = cell_bus_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_b,
	cell_bus_if.phy link,
	output cell_bus_pkg::octet_t user_tx_data,
	output logic user_tx_soc,
	output logic user_tx_valid,
	input wire logic user_tx_ready,
	output logic user_tx_err,
	input wire cell_bus_pkg::octet_t user_rx_data,
	input wire logic user_rx_valid,
	output logic user_rx_ready
);
	localparam int LW = $clog2(DEPTH) + 1;

	// a store must hold at least a whole cell plus the full margin
	if (DEPTH < cell_bus_pkg::CELL_BYTES + cell_bus_pkg::FULL_ROOM) begin : g_bad_depth
		$error("phy_port depth too small for one cell");
	end

	// two-stage sampling of every pin driven by the atm end
	logic [12:0] sync1_ff;
	logic [12:0] sync2_ff;
	logic tx_clk_d_ff;
	logic rx_clk_d_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {link.tx_clk, link.rx_clk, link.tx_enb_n, link.tx_soc,
				link.tx_data, link.rx_enb_n};
			sync2_ff <= sync1_ff;
		end
	end

	wire s_tx_clk = sync2_ff[12];
	wire s_rx_clk = sync2_ff[11];
	wire s_tx_enb_n = sync2_ff[10];
	wire s_tx_soc = sync2_ff[9];
	wire [7:0] s_tx_data = sync2_ff[8:1];
	wire s_rx_enb_n = sync2_ff[0];

	// edge finders on each direction's own clock
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tx_clk_d_ff <= 1'b0;
			rx_clk_d_ff <= 1'b0;
		end else begin
			tx_clk_d_ff <= s_tx_clk;
			rx_clk_d_ff <= s_rx_clk;
		end
	end

	wire tx_rise = s_tx_clk && !tx_clk_d_ff;
	wire tx_fall = !s_tx_clk && tx_clk_d_ff;
	wire rx_rise = s_rx_clk && !rx_clk_d_ff;
	wire rx_fall = !s_rx_clk && rx_clk_d_ff;

	// transmit store: one entry per enabled byte, start mark kept beside it
	logic [8:0] txf_out;
	logic [LW-1:0] txf_level;
	logic txf_avail;
	logic txf_pop;
	wire tx_take = tx_rise && !s_tx_enb_n;

	cell_fifo #(
		.WIDTH(9),
		.DEPTH(DEPTH)
	) u_tx_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.push(tx_take),
		.push_data({s_tx_soc, s_tx_data}),
		.pop(txf_pop),
		.pop_data(txf_out),
		.level_ff(txf_level),
		.room_ff(),
		.avail_ff(txf_avail)
	);

	// room left in the transmit store
	wire [LW-1:0] tx_free = LW'(DEPTH) - txf_level;
	wire nxt_full_n = CELL_LEVEL || (tx_free > LW'(cell_bus_pkg::FULL_ROOM));
	wire nxt_tx_clav = tx_free >= LW'(cell_bus_pkg::CELL_BYTES);

	// transmit flags change only on the transmit clock's falling edge
	logic tx_full_n_ff;
	logic tx_clav_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tx_full_n_ff <= cell_bus_pkg::FLAG_RST;
			tx_clav_ff <= cell_bus_pkg::FLAG_RST;
		end else if (tx_fall) begin
			tx_full_n_ff <= nxt_full_n;
			tx_clav_ff <= nxt_tx_clav;
		end
	end

	assign link.tx_full_n = tx_full_n_ff;
	assign link.tx_clav = tx_clav_ff;

	// cell framing check on arriving bytes: the start mark must fall on byte 0
	logic [5:0] tx_pos_ff;
	logic tx_err_ff;
	wire tx_soc_bad = s_tx_soc != (tx_pos_ff == '0);
	wire [5:0] tx_pos_base = s_tx_soc ? 6'h00 : tx_pos_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tx_pos_ff <= '0;
			tx_err_ff <= 1'b0;
		end else begin
			tx_err_ff <= tx_take && tx_soc_bad;
			if (tx_take) begin
				tx_pos_ff <= (tx_pos_base == cell_bus_pkg::CELL_LAST) ? 6'h00 :
					tx_pos_base + 6'h01;
			end
		end
	end

	assign user_tx_err = tx_err_ff;

	// registered output stage toward the user, loaded when empty or drained
	logic utx_valid_ff;
	cell_bus_pkg::octet_t utx_data_ff;
	logic utx_soc_ff;
	assign txf_pop = txf_avail && (!utx_valid_ff || user_tx_ready);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			utx_valid_ff <= 1'b0;
			utx_data_ff <= cell_bus_pkg::DATA_RST;
			utx_soc_ff <= 1'b0;
		end else if (txf_pop) begin
			utx_valid_ff <= 1'b1;
			utx_data_ff <= txf_out[7:0];
			utx_soc_ff <= txf_out[8];
		end else if (user_tx_ready) begin
			utx_valid_ff <= 1'b0;
		end
	end

	assign user_tx_valid = utx_valid_ff;
	assign user_tx_data = utx_data_ff;
	assign user_tx_soc = utx_soc_ff;

	// receive store filled by the user; start mark made from its own count
	logic [8:0] rxf_out;
	logic [LW-1:0] rxf_level;
	logic rxf_room;
	logic rxf_avail;
	logic [5:0] rx_wpos_ff;
	wire rx_push = user_rx_valid && rxf_room;
	wire rx_load;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rx_wpos_ff <= '0;
		end else if (rx_push) begin
			rx_wpos_ff <= (rx_wpos_ff == cell_bus_pkg::CELL_LAST) ? 6'h00 :
				rx_wpos_ff + 6'h01;
		end
	end

	cell_fifo #(
		.WIDTH(9),
		.DEPTH(DEPTH)
	) u_rx_fifo (
		.clock(clock),
		.rst_b(rst_b),
		.push(rx_push),
		.push_data({rx_wpos_ff == '0, user_rx_data}),
		.pop(rx_load),
		.pop_data(rxf_out),
		.level_ff(rxf_level),
		.room_ff(rxf_room),
		.avail_ff(rxf_avail)
	);

	assign user_rx_ready = rxf_room;

	// byte presented on the bus; hold marks that it has not been taken yet
	logic hold_ff;
	cell_bus_pkg::octet_t rx_data_ff;
	logic rx_soc_ff;
	logic rx_empty_n_ff;
	logic rx_clav_ff;
	assign rx_load = rx_fall && !hold_ff && rxf_avail;
	wire [LW-1:0] rx_held = rxf_level + LW'(hold_ff);

	// take on the rising edge, present the next byte on the falling edge
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			hold_ff <= 1'b0;
			rx_data_ff <= cell_bus_pkg::DATA_RST;
			rx_soc_ff <= 1'b0;
		end else if (rx_rise && !s_rx_enb_n) begin
			hold_ff <= 1'b0;
		end else if (rx_load) begin
			hold_ff <= 1'b1;
			rx_data_ff <= rxf_out[7:0];
			rx_soc_ff <= rxf_out[8];
		end else if (rx_fall && !hold_ff) begin
			rx_soc_ff <= 1'b0;
		end
	end

	// receive flags count the presented byte plus the stored ones
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rx_empty_n_ff <= cell_bus_pkg::FLAG_RST;
			rx_clav_ff <= cell_bus_pkg::FLAG_RST;
		end else if (rx_fall) begin
			rx_empty_n_ff <= CELL_LEVEL || (rx_held != '0);
			rx_clav_ff <= rx_held >= LW'(cell_bus_pkg::CELL_BYTES);
		end
	end

	assign link.rx_data = rx_data_ff;
	assign link.rx_soc = rx_soc_ff;
	assign link.rx_empty_n = rx_empty_n_ff;
	assign link.rx_clav = rx_clav_ff;
endmodule : phy_port
`default_nettype wire

/* logic/atm_port.sv */
// atm_port: atm-layer end of the cell bus; makes both link clocks by dividers.
// assumes the phy-driven pins come from another domain and are sampled here.
`timescale 1ns/1ps
`default_nettype none
module atm_port #(
	parameter bit CELL_LEVEL = 1'b0,
	parameter int TX_HALF = cell_bus_pkg::LINK_HALF_CYC,
	parameter int RX_HALF = cell_bus_pkg::LINK_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	cell_bus_if.atm link,
	input wire cell_bus_pkg::octet_t user_tx_data,
	input wire logic user_tx_valid,
	output logic user_tx_ready,
	output cell_bus_pkg::octet_t user_rx_data,
	output logic user_rx_soc,
	output logic user_rx_valid
);
	// the phy end needs several system cycles per link half period
	if (TX_HALF < 4 || TX_HALF > 255 || RX_HALF < 4 || RX_HALF > 255) begin : g_bad_half
		$error("atm_port link half period out of range");
	end

	// separate dividers: each direction has its own clock
	logic [7:0] tdiv_ff;
	logic [7:0] rdiv_ff;
	logic tx_clk_ff;
	logic rx_clk_ff;
	wire twrap = tdiv_ff == 8'(TX_HALF - 1);
	wire rwrap = rdiv_ff == 8'(RX_HALF - 1);
	wire tx_rise = twrap && !tx_clk_ff;
	wire tx_fall = twrap && tx_clk_ff;
	wire rx_rise = rwrap && !rx_clk_ff;
	wire rx_fall = rwrap && rx_clk_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tdiv_ff <= '0;
			rdiv_ff <= '0;
			tx_clk_ff <= 1'b0;
			rx_clk_ff <= 1'b0;
		end else begin
			tdiv_ff <= twrap ? 8'h00 : tdiv_ff + 8'h01;
			rdiv_ff <= rwrap ? 8'h00 : rdiv_ff + 8'h01;
			tx_clk_ff <= tx_clk_ff ^ twrap;
			rx_clk_ff <= rx_clk_ff ^ rwrap;
		end
	end

	// two-stage sampling of the phy-driven pins
	// map: full_n 12, tx clav 11, data 10:3, soc 2, empty_n 1, rx clav 0
	logic [12:0] sync1_ff;
	logic [12:0] sync2_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {link.tx_full_n, link.tx_clav, link.rx_data, link.rx_soc,
				link.rx_empty_n, link.rx_clav};
			sync2_ff <= sync1_ff;
		end
	end

	// flags captured on their direction's rising edge
	logic full_seen_ff;
	logic tclav_seen_ff;
	logic empty_seen_ff;
	logic rclav_seen_ff;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			full_seen_ff <= 1'b0;
			tclav_seen_ff <= 1'b0;
			empty_seen_ff <= 1'b0;
			rclav_seen_ff <= 1'b0;
		end else begin
			if (tx_rise) begin
				full_seen_ff <= sync2_ff[12];
				tclav_seen_ff <= sync2_ff[11];
			end
			if (rx_rise) begin
				empty_seen_ff <= sync2_ff[1];
				rclav_seen_ff <= sync2_ff[0];
			end
		end
	end

	// transmit: one staged byte, written on the falling edge when allowed
	logic stg_valid_ff;
	cell_bus_pkg::octet_t stg_data_ff;
	logic ready_ff;
	logic [5:0] tpos_ff;
	logic tx_enb_n_ff;
	logic tx_soc_ff;
	cell_bus_pkg::octet_t tx_data_ff;
	cell_bus_pkg::link_state_e tst_ff;
	cell_bus_pkg::link_state_e nxt_tst;
	wire accept = user_tx_valid && ready_ff;
	wire tcell_go = (tst_ff == cell_bus_pkg::LS_CELL) || (tclav_seen_ff && tx_enb_n_ff);
	wire tx_write = tx_fall && stg_valid_ff && (CELL_LEVEL ? tcell_go : full_seen_ff);
	wire tlast = tpos_ff == cell_bus_pkg::CELL_LAST;
	wire nxt_stg = (stg_valid_ff && !tx_write) || accept;

	// cell-level transmit state: stays in a cell until its last byte
	always_comb begin
		nxt_tst = tst_ff;
		case (tst_ff)
			cell_bus_pkg::LS_IDLE: begin
				if (tx_write && CELL_LEVEL) nxt_tst = cell_bus_pkg::LS_CELL;
			end
			cell_bus_pkg::LS_CELL: begin
				if (tx_write && tlast) nxt_tst = cell_bus_pkg::LS_IDLE;
			end
			default: nxt_tst = cell_bus_pkg::LS_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stg_valid_ff <= 1'b0;
			stg_data_ff <= cell_bus_pkg::DATA_RST;
			ready_ff <= 1'b0;
			tst_ff <= cell_bus_pkg::LS_IDLE;
			tpos_ff <= '0;
		end else begin
			stg_valid_ff <= nxt_stg;
			ready_ff <= !nxt_stg;
			tst_ff <= nxt_tst;
			if (accept) stg_data_ff <= user_tx_data;
			if (tx_write) tpos_ff <= tlast ? 6'h00 : tpos_ff + 6'h01;
		end
	end

	// transmit pins change on the falling edge only
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tx_enb_n_ff <= cell_bus_pkg::ENB_IDLE_N;
			tx_soc_ff <= 1'b0;
			tx_data_ff <= cell_bus_pkg::DATA_RST;
		end else if (tx_fall) begin
			tx_enb_n_ff <= !tx_write;
			tx_soc_ff <= tx_write && tpos_ff == '0;
			if (tx_write) tx_data_ff <= stg_data_ff;
		end
	end

	// receive: enable on the falling edge, byte taken on the next rising edge
	logic rx_enb_n_ff;
	logic [5:0] rpos_ff;
	logic urx_valid_ff;
	cell_bus_pkg::octet_t urx_data_ff;
	logic urx_soc_ff;
	wire rlast = rpos_ff == cell_bus_pkg::CELL_LAST;
	wire rcell_go = (rpos_ff != '0) || (rclav_seen_ff && rx_enb_n_ff);
	wire rx_ask = rx_fall && (CELL_LEVEL ? rcell_go : (empty_seen_ff && rx_enb_n_ff));

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rx_enb_n_ff <= cell_bus_pkg::ENB_IDLE_N;
			rpos_ff <= '0;
		end else if (rx_fall) begin
			rx_enb_n_ff <= !rx_ask;
			if (rx_ask) rpos_ff <= rlast ? 6'h00 : rpos_ff + 6'h01;
		end
	end

	// one-cycle pulse to the user for each byte taken
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			urx_valid_ff <= 1'b0;
			urx_data_ff <= cell_bus_pkg::DATA_RST;
			urx_soc_ff <= 1'b0;
		end else begin
			urx_valid_ff <= rx_rise && !rx_enb_n_ff;
			if (rx_rise && !rx_enb_n_ff) begin
				urx_data_ff <= sync2_ff[10:3];
				urx_soc_ff <= sync2_ff[2];
			end
		end
	end

	assign user_tx_ready = ready_ff;
	assign user_rx_valid = urx_valid_ff;
	assign user_rx_data = urx_data_ff;
	assign user_rx_soc = urx_soc_ff;
	assign link.tx_clk = tx_clk_ff;
	assign link.rx_clk = rx_clk_ff;
	assign link.tx_enb_n = tx_enb_n_ff;
	assign link.tx_soc = tx_soc_ff;
	assign link.tx_data = tx_data_ff;
	assign link.rx_enb_n = rx_enb_n_ff;
endmodule : atm_port
`default_nettype wire

/* bench/cell_bus_assertions.sv */
// cell_bus_assertions: timing and framing checks on the octet-mode cell bus.
// assumes both ends share clock and rst_b and both link half periods are 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module cell_bus_assertions (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic tx_clk,
	input wire cell_bus_pkg::octet_t tx_data,
	input wire logic tx_enb_n,
	input wire logic tx_soc,
	input wire logic tx_full_n,
	input wire logic tx_clav,
	input wire logic rx_clk,
	input wire cell_bus_pkg::octet_t rx_data,
	input wire logic rx_enb_n,
	input wire logic rx_soc,
	input wire logic rx_empty_n,
	input wire logic rx_clav
);
	logic txc_ff, rxc_ff;
	logic [5:0] tcnt_ff, rcnt_ff, nxt_tcnt, nxt_rcnt;
	logic [3:0] late_ff, nxt_late;
	logic tx_rise, rx_rise, tx_take, rx_take;
	// link rises seen on the system clock, and bytes taken at them
	assign tx_rise = tx_clk & ~txc_ff;
	assign rx_rise = rx_clk & ~rxc_ff;
	assign tx_take = tx_rise & ~tx_enb_n;
	assign rx_take = rx_rise & ~rx_enb_n;
	assign nxt_tcnt = (tcnt_ff == cell_bus_pkg::CELL_LAST) ? 6'h00 : tcnt_ff + 6'h01;
	assign nxt_rcnt = (rcnt_ff == cell_bus_pkg::CELL_LAST) ? 6'h00 : rcnt_ff + 6'h01;
	// writes taken since the full indication was last seen high, saturating
	assign nxt_late = !tx_rise ? late_ff : tx_full_n ? 4'h0 :
		(tx_take && late_ff != 4'hf) ? late_ff + 4'h1 : late_ff;
	// byte position counters and edge history
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			txc_ff <= 1'b0;
			rxc_ff <= 1'b0;
			tcnt_ff <= 6'h00;
			rcnt_ff <= 6'h00;
			late_ff <= 4'h0;
		end else begin
			txc_ff <= tx_clk;
			rxc_ff <= rx_clk;
			tcnt_ff <= tx_take ? nxt_tcnt : tcnt_ff;
			rcnt_ff <= rx_take ? nxt_rcnt : rcnt_ff;
			late_ff <= nxt_late;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	tx_half_a: assert property ($rose(tx_clk) |-> tx_clk [*8] ##1 !tx_clk)
		else $error("transmit link clock high phase wrong");
	rx_half_a: assert property ($fell(rx_clk) |-> !rx_clk [*8] ##1 rx_clk)
		else $error("receive link clock low phase wrong");
	tx_hold_a: assert property ($rose(tx_clk) |=> $stable(tx_data) [*7])
		else $error("transmit byte moved during high phase");
	rx_change_a: assert property ($changed(rx_data) || $changed(rx_soc) |-> !rx_clk)
		else $error("receive pins moved while link clock high");
	tx_soc_enb_a: assert property (tx_soc |-> !tx_enb_n)
		else $error("start mark without transmit enable");
	tx_soc_pos_a: assert property (tx_take |-> tx_soc == (tcnt_ff == 6'h00))
		else $error("transmit start mark off cell boundary");
	rx_soc_pos_a: assert property (rx_take |-> rx_soc == (rcnt_ff == 6'h00))
		else $error("receive start mark off cell boundary");
	full_stop_a: assert property (late_ff <= 4'(cell_bus_pkg::FULL_ROOM))
		else $error("too many writes after full");
	tx_cell_c: cover property (tx_take && tx_soc);
	rx_cell_c: cover property (rx_take && rx_soc);
	full_c: cover property (tx_rise && !tx_full_n);
endmodule : cell_bus_assertions
`default_nettype wire

/* bench/tb_top.sv */
// tb_top: both ends joined back to back, octet pair 0 and cell pair 1.
// assumes the atm end makes both link clocks at its default divide.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int NB = 2 * cell_bus_pkg::CELL_BYTES;
	logic clock, rst_b;
	cell_bus_pkg::octet_t a_txd [2], a_rxd [2], p_txd [2], p_rxd [2];
	logic a_txv [2], a_txr [2], a_rxs [2], a_rxv [2], p_txs [2], p_txv [2];
	logic p_txr [2], p_txe [2], p_rxv [2], p_rxr [2], go [2];
	logic stall_w [2], enb_w [2], rxf_w [2], saw_rx [2];
	int nts [2], nrs [2], ntx [2], nrx [2], nerr [2];
	logic [8:0] gtx [2][128], grx [2][128];
	int n_errors, checked;
	cell_bus_if bus [2] ();

	// system clock
	always #5 clock = ~clock;

	function automatic cell_bus_pkg::octet_t pat(input int m, input int i, input bit dir);
		return 8'(i * 3 + m * 7 + (dir ? 128 : 0));
	endfunction : pat

	// one pair of ends per handshake mode, with feeders and collectors
	for (genvar g = 0; g < 2; g++) begin : pair
		atm_port #(.CELL_LEVEL(g == 1)) atm_port_i (.clock(clock), .rst_b(rst_b),
			.link(bus[g]), .user_tx_data(a_txd[g]), .user_tx_valid(a_txv[g]),
			.user_tx_ready(a_txr[g]), .user_rx_data(a_rxd[g]), .user_rx_soc(a_rxs[g]),
			.user_rx_valid(a_rxv[g]));
		phy_port #(.CELL_LEVEL(g == 1), .DEPTH(64)) phy_port_i (.clock(clock),
			.rst_b(rst_b), .link(bus[g]), .user_tx_data(p_txd[g]), .user_tx_soc(p_txs[g]),
			.user_tx_valid(p_txv[g]), .user_tx_ready(p_txr[g]), .user_tx_err(p_txe[g]),
			.user_rx_data(p_rxd[g]), .user_rx_valid(p_rxv[g]), .user_rx_ready(p_rxr[g]));
		assign stall_w[g] = (g == 1) ? bus[g].tx_clav : bus[g].tx_full_n;
		assign enb_w[g] = bus[g].tx_enb_n;
		assign rxf_w[g] = (g == 1) ? bus[g].rx_clav : bus[g].rx_empty_n;
		always @(posedge clock) begin
			if (a_txv[g] === 1'b1 && a_txr[g] === 1'b1) nts[g] = nts[g] + 1;
			if (p_rxv[g] === 1'b1 && p_rxr[g] === 1'b1) nrs[g] = nrs[g] + 1;
			a_txv[g] <= go[g] && nts[g] < NB;
			a_txd[g] <= pat(g, nts[g], 1'b0);
			p_rxv[g] <= go[g] && nrs[g] < NB;
			p_rxd[g] <= pat(g, nrs[g], 1'b1);
			if (p_txv[g] === 1'b1 && p_txr[g] === 1'b1 && ntx[g] < 128) begin
				gtx[g][ntx[g]] = {p_txs[g], p_txd[g]};
				ntx[g] = ntx[g] + 1;
			end
			if (a_rxv[g] === 1'b1 && nrx[g] < 128) begin
				grx[g][nrx[g]] = {a_rxs[g], a_rxd[g]};
				nrx[g] = nrx[g] + 1;
			end
			if (p_txe[g] === 1'b1) nerr[g] = nerr[g] + 1;
			if (rxf_w[g] === 1'b1) saw_rx[g] = 1'b1;
		end
	end

	cell_bus_assertions cell_bus_assertions_i (.clock(clock), .rst_b(rst_b),
		.tx_clk(bus[0].tx_clk), .tx_data(bus[0].tx_data), .tx_enb_n(bus[0].tx_enb_n),
		.tx_soc(bus[0].tx_soc), .tx_full_n(bus[0].tx_full_n), .tx_clav(bus[0].tx_clav),
		.rx_clk(bus[0].rx_clk), .rx_data(bus[0].rx_data), .rx_enb_n(bus[0].rx_enb_n),
		.rx_soc(bus[0].rx_soc), .rx_empty_n(bus[0].rx_empty_n), .rx_clav(bus[0].rx_clav));

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		$display("checks=%0d errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// both directions at once, with the phy user side stalled first
	task automatic run_mode(input int m);
		int k;
		@(posedge clock);
		go[m] <= 1'b1;
		for (k = 0; k < 4000 && stall_w[m] !== 1'b1; k++) @(posedge clock);
		for (k = 0; k < 4000 && stall_w[m] !== 1'b0; k++) @(posedge clock);
		check(9'(stall_w[m]), 9'h000);
		// long enough for a cell already under way to finish its 53 bytes
		repeat (1024) @(posedge clock);
		check(9'(enb_w[m]), 9'h001);
		p_txr[m] <= 1'b1;
		for (k = 0; k < 8000 && (ntx[m] < NB || nrx[m] < NB); k++) @(posedge clock);
		repeat (64) @(posedge clock);
		check(9'(ntx[m]), 9'(NB));
		check(9'(nrx[m]), 9'(NB));
		for (int i = 0; i < NB; i++) begin
			check(gtx[m][i], {i % cell_bus_pkg::CELL_BYTES == 0, pat(m, i, 1'b0)});
			check(grx[m][i], {i % cell_bus_pkg::CELL_BYTES == 0, pat(m, i, 1'b1)});
		end
		check(9'(nerr[m]), 9'h000);
		check(9'(rxf_w[m]), 9'h000);
		check(9'(saw_rx[m]), 9'h001);
	endtask : run_mode

	// reset, then octet mode and cell mode in turn
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		n_errors = 0;
		checked = 0;
		for (int m = 0; m < 2; m++) begin
			{a_txv[m], p_rxv[m], p_txr[m], go[m], saw_rx[m]} = 5'h00;
			{a_txd[m], p_rxd[m]} = 16'h0000;
			{nts[m], nrs[m], ntx[m], nrx[m], nerr[m]} = '0;
		end
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		run_mode(0);
		run_mode(1);
		final_report();
	end

	// watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge clock);
		n_errors++;
		final_report();
	end
endmodule : tb_top
`default_nettype wire
